/* rtl/rtcb_pkg.sv */
// rtcb_pkg: constants and types of the decimal clock, calendar and alarm registers
package rtcb_pkg;

    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [3:0] RTCB_ADDR_SS      = 4'h0;
    localparam logic [3:0] RTCB_ADDR_MM      = 4'h1;
    localparam logic [3:0] RTCB_ADDR_HH      = 4'h2;
    localparam logic [3:0] RTCB_ADDR_DOW     = 4'h3;
    localparam logic [3:0] RTCB_ADDR_DD      = 4'h4;
    localparam logic [3:0] RTCB_ADDR_MO      = 4'h5;
    localparam logic [3:0] RTCB_ADDR_YY      = 4'h6;
    localparam logic [3:0] RTCB_ADDR_ALM_MM  = 4'h7;
    localparam logic [3:0] RTCB_ADDR_ALM_HH  = 4'h8;
    localparam logic [3:0] RTCB_ADDR_ALM_DAY = 4'h9;

    // -------------------------------------------------------------
    // implemented bits of each register
    // -------------------------------------------------------------
    localparam logic [7:0] RTCB_MASK_SS  = 8'h7f;
    localparam logic [7:0] RTCB_MASK_MM  = 8'h7f;
    localparam logic [7:0] RTCB_MASK_HH  = 8'h3f;
    localparam logic [7:0] RTCB_MASK_DOW = 8'h7f;
    localparam logic [7:0] RTCB_MASK_DD  = 8'h3f;
    localparam logic [7:0] RTCB_MASK_MO  = 8'h1f;
    localparam logic [7:0] RTCB_MASK_YY  = 8'hff;
    localparam logic [7:0] RTCB_MASK_ALM = 8'hff;

    // -------------------------------------------------------------
    // counting ranges in bcd
    // -------------------------------------------------------------
    localparam logic [7:0] RTCB_SS_FIRST = 8'h00;
    localparam logic [7:0] RTCB_SS_LAST  = 8'h59;
    localparam logic [7:0] RTCB_HH_LAST  = 8'h23;
    localparam logic [7:0] RTCB_DD_FIRST = 8'h01;
    localparam logic [7:0] RTCB_DD_28    = 8'h28;
    localparam logic [7:0] RTCB_DD_29    = 8'h29;
    localparam logic [7:0] RTCB_DD_30    = 8'h30;
    localparam logic [7:0] RTCB_DD_31    = 8'h31;
    localparam logic [7:0] RTCB_MO_FEB   = 8'h02;
    localparam logic [7:0] RTCB_MO_APR   = 8'h04;
    localparam logic [7:0] RTCB_MO_JUN   = 8'h06;
    localparam logic [7:0] RTCB_MO_SEP   = 8'h09;
    localparam logic [7:0] RTCB_MO_NOV   = 8'h11;
    localparam logic [7:0] RTCB_MO_LAST  = 8'h12;
    localparam logic [7:0] RTCB_YY_LAST  = 8'h99;
    localparam logic [3:0] RTCB_DIGIT_NINE = 4'h9;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int         RTCB_OFF_BIT    = 7;
    localparam int         RTCB_DOW_MSB    = 6;
    localparam logic [6:0] RTCB_DOW_SUNDAY = 7'h01;
    localparam logic [7:0] RTCB_ALM_RESET  = 8'h80;
    localparam logic [7:0] RTCB_ZERO       = 8'h00;
    localparam logic [9:0] RTCB_FRAC_LAST  = 10'h3ff;
    localparam logic [9:0] RTCB_FRAC_ZERO  = 10'h000;

    // -------------------------------------------------------------
    // host register request
    // -------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [3:0] addr;
        logic [7:0] wdata;
    } rtcb_req_t;

    // mode levels held outside this block
    typedef struct packed {
        logic access_decimal_select;
        logic decimal_counter_run;
        logic alarm_day_select;
        logic alarm_irq_en;
    } rtcb_mode_t;

endpackage : rtcb_pkg

/* rtl/rtcb_bcd_cnt.sv */
// rtcb_bcd_cnt: two-digit bcd counter with host load and wrap
`timescale 1ns/1ps
module rtcb_bcd_cnt
    import rtcb_pkg::*;
#(
    parameter logic [7:0] INIT = 8'h00
)
(
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_step,
    input  wire logic [7:0] i_first,
    input  wire logic [7:0] i_last,
    output logic      [7:0] o_value,
    output logic            o_carry
);

    logic [7:0] value_ff;
    logic [7:0] nxt_value;

    // -------------------------------------------------------------
    // next value: host write wins over counting
    // -------------------------------------------------------------
    always_comb
    begin
        nxt_value = value_ff;
        if (i_wr)
        begin
            nxt_value = i_wdata;
        end
        else if (i_step)
        begin
            if (value_ff >= i_last)
            begin
                nxt_value = i_first;
            end
            else if (value_ff[3:0] >= RTCB_DIGIT_NINE)
            begin
                nxt_value = {value_ff[7:4] + 4'h1, 4'h0};
            end
            else
            begin
                nxt_value = {value_ff[7:4], value_ff[3:0] + 4'h1};
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            value_ff <= INIT;
        end
        else
        begin
            value_ff <= nxt_value;
        end
    end

    assign o_value = value_ff;
    assign o_carry = i_step && !i_wr && (value_ff >= i_last);

endmodule : rtcb_bcd_cnt

/* rtl/rtcb_regs.sv */
// rtcb_regs: decimal time, calendar and alarm registers of the real-time clock
`timescale 1ns/1ps
module rtcb_regs
    import rtcb_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire rtcb_req_t  i_req,
    input  wire rtcb_mode_t i_mode,
    input  wire logic       i_tick_1024,
    output logic      [7:0] o_rdata,
    output logic            o_rvalid,
    output logic      [9:0] o_fraction,
    output logic            o_alarm_match,
    output logic            o_alarm_pulse
);

    // -------------------------------------------------------------
    // declarations
    // -------------------------------------------------------------
    logic       access_ok, run, sec_step, leap_year;
    logic       wr_ss, wr_mm, wr_hh, wr_dow, wr_dd;
    logic       wr_mo, wr_yy, wr_alm_mm, wr_alm_hh, wr_alm_day;
    logic [9:0] frac_ff, nxt_frac;
    logic [7:0] ss_val, mm_val, hh_val, dd_val, mo_val, yy_val;
    logic       ss_carry, mm_carry, hh_carry, dd_carry, mo_carry;
    logic [6:0] dow_ff, nxt_dow;
    logic [7:0] alm_mm_ff, alm_hh_ff, alm_day_ff;
    logic [7:0] dd_last;
    logic       mm_term, hh_term, day_term, any_enabled, alarm_cond;
    logic       alarm_match_ff, alarm_pulse_ff, rvalid_ff;
    logic [7:0] rdata_ff, nxt_rdata;

    // -------------------------------------------------------------
    // access decode
    // -------------------------------------------------------------
    assign access_ok  = i_mode.access_decimal_select && i_mode.decimal_counter_run;
    assign run        = i_mode.decimal_counter_run;
    assign wr_ss      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_SS);
    assign wr_mm      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_MM);
    assign wr_hh      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_HH);
    assign wr_dow     = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_DOW);
    assign wr_dd      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_DD);
    assign wr_mo      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_MO);
    assign wr_yy      = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_YY);
    assign wr_alm_mm  = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_ALM_MM);
    assign wr_alm_hh  = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_ALM_HH);
    assign wr_alm_day = i_req.wr && access_ok && (i_req.addr == RTCB_ADDR_ALM_DAY);

    // -------------------------------------------------------------
    // 1/1024 second prescaler and fraction count
    // -------------------------------------------------------------
    assign sec_step = run && i_tick_1024 && (frac_ff == RTCB_FRAC_LAST) && !wr_ss;

    always_comb
    begin
        nxt_frac = frac_ff;
        if (wr_ss)
        begin
            nxt_frac = RTCB_FRAC_ZERO;
        end
        else if (run && i_tick_1024)
        begin
            nxt_frac = frac_ff + 10'h001;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            frac_ff <= RTCB_FRAC_ZERO;
        end
        else
        begin
            frac_ff <= nxt_frac;
        end
    end

    // -------------------------------------------------------------
    // time counters
    // -------------------------------------------------------------
    rtcb_bcd_cnt #(.INIT(RTCB_SS_FIRST)) u_ss (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_ss),
        .i_wdata  (i_req.wdata & RTCB_MASK_SS),
        .i_step   (sec_step),
        .i_first  (RTCB_SS_FIRST),
        .i_last   (RTCB_SS_LAST),
        .o_value  (ss_val),
        .o_carry  (ss_carry)
    );

    rtcb_bcd_cnt #(.INIT(RTCB_SS_FIRST)) u_mm (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_mm),
        .i_wdata  (i_req.wdata & RTCB_MASK_MM),
        .i_step   (ss_carry),
        .i_first  (RTCB_SS_FIRST),
        .i_last   (RTCB_SS_LAST),
        .o_value  (mm_val),
        .o_carry  (mm_carry)
    );

    rtcb_bcd_cnt #(.INIT(RTCB_SS_FIRST)) u_hh (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_hh),
        .i_wdata  (i_req.wdata & RTCB_MASK_HH),
        .i_step   (mm_carry),
        .i_first  (RTCB_SS_FIRST),
        .i_last   (RTCB_HH_LAST),
        .o_value  (hh_val),
        .o_carry  (hh_carry)
    );

    // -------------------------------------------------------------
    // calendar counters
    // -------------------------------------------------------------
    // leap when bcd year is a multiple of four
    assign leap_year = yy_val[4] ? ((yy_val[3:0] == 4'h2) || (yy_val[3:0] == 4'h6))
                                 : ((yy_val[3:0] == 4'h0) || (yy_val[3:0] == 4'h4)
                                    || (yy_val[3:0] == 4'h8));

    always_comb
    begin
        case (mo_val)
            RTCB_MO_FEB: dd_last = leap_year ? RTCB_DD_29 : RTCB_DD_28;
            RTCB_MO_APR,
            RTCB_MO_JUN,
            RTCB_MO_SEP,
            RTCB_MO_NOV: dd_last = RTCB_DD_30;
            default:     dd_last = RTCB_DD_31;
        endcase
    end

    rtcb_bcd_cnt #(.INIT(RTCB_DD_FIRST)) u_dd (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_dd),
        .i_wdata  (i_req.wdata & RTCB_MASK_DD),
        .i_step   (hh_carry),
        .i_first  (RTCB_DD_FIRST),
        .i_last   (dd_last),
        .o_value  (dd_val),
        .o_carry  (dd_carry)
    );

    rtcb_bcd_cnt #(.INIT(RTCB_DD_FIRST)) u_mo (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_mo),
        .i_wdata  (i_req.wdata & RTCB_MASK_MO),
        .i_step   (dd_carry),
        .i_first  (RTCB_DD_FIRST),
        .i_last   (RTCB_MO_LAST),
        .o_value  (mo_val),
        .o_carry  (mo_carry)
    );

    rtcb_bcd_cnt #(.INIT(RTCB_SS_FIRST)) u_yy (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (wr_yy),
        .i_wdata  (i_req.wdata & RTCB_MASK_YY),
        .i_step   (mo_carry),
        .i_first  (RTCB_SS_FIRST),
        .i_last   (RTCB_YY_LAST),
        .o_value  (yy_val),
        .o_carry  ()
    );

    // -------------------------------------------------------------
    // day of week, one-hot from reset, host write loads any 7 bits, rotates with each day advance
    // -------------------------------------------------------------
    always_comb
    begin
        nxt_dow = dow_ff;
        if (wr_dow)
        begin
            nxt_dow = i_req.wdata[6:0];
        end
        else if (hh_carry)
        begin
            nxt_dow = {dow_ff[RTCB_DOW_MSB-1:0], dow_ff[RTCB_DOW_MSB]};
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            dow_ff <= RTCB_DOW_SUNDAY;
        end
        else
        begin
            dow_ff <= nxt_dow;
        end
    end

    // -------------------------------------------------------------
    // alarm storage, plain read/write registers
    // -------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            alm_mm_ff  <= RTCB_ALM_RESET;
            alm_hh_ff  <= RTCB_ALM_RESET;
            alm_day_ff <= RTCB_ALM_RESET;
        end
        else
        begin
            if (wr_alm_mm)
            begin
                alm_mm_ff <= i_req.wdata & RTCB_MASK_ALM;
            end
            if (wr_alm_hh)
            begin
                alm_hh_ff <= i_req.wdata & RTCB_MASK_ALM;
            end
            if (wr_alm_day)
            begin
                alm_day_ff <= i_req.wdata & RTCB_MASK_ALM;
            end
        end
    end

    // -------------------------------------------------------------
    // alarm compare
    // -------------------------------------------------------------
    assign mm_term  = alm_mm_ff[RTCB_OFF_BIT]
                      || (alm_mm_ff[6:0] == mm_val[6:0]);
    assign hh_term  = alm_hh_ff[RTCB_OFF_BIT]
                      || (alm_hh_ff[5:0] == hh_val[5:0]);
    assign day_term = alm_day_ff[RTCB_OFF_BIT]
                      || (i_mode.alarm_day_select
                          ? (alm_day_ff[5:0] == dd_val[5:0])
                          : ((alm_day_ff[6:0] & dow_ff) != 7'h00));
    assign any_enabled = !alm_mm_ff[RTCB_OFF_BIT] || !alm_hh_ff[RTCB_OFF_BIT]
                         || !alm_day_ff[RTCB_OFF_BIT];
    assign alarm_cond  = run && any_enabled && mm_term && hh_term && day_term;

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            alarm_match_ff <= 1'b0;
            alarm_pulse_ff <= 1'b0;
        end
        else
        begin
            alarm_match_ff <= alarm_cond;
            alarm_pulse_ff <= alarm_cond && !alarm_match_ff && i_mode.alarm_irq_en;
        end
    end

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = RTCB_ZERO;
        if (access_ok)
        begin
            case (i_req.addr)
                RTCB_ADDR_SS:      nxt_rdata = ss_val & RTCB_MASK_SS;
                RTCB_ADDR_MM:      nxt_rdata = mm_val & RTCB_MASK_MM;
                RTCB_ADDR_HH:      nxt_rdata = hh_val & RTCB_MASK_HH;
                RTCB_ADDR_DOW:     nxt_rdata = {1'b0, dow_ff};
                RTCB_ADDR_DD:      nxt_rdata = dd_val & RTCB_MASK_DD;
                RTCB_ADDR_MO:      nxt_rdata = mo_val & RTCB_MASK_MO;
                RTCB_ADDR_YY:      nxt_rdata = yy_val;
                RTCB_ADDR_ALM_MM:  nxt_rdata = alm_mm_ff;
                RTCB_ADDR_ALM_HH:  nxt_rdata = alm_hh_ff;
                RTCB_ADDR_ALM_DAY: nxt_rdata = alm_day_ff;
                default:           nxt_rdata = RTCB_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            rdata_ff  <= RTCB_ZERO;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rvalid_ff <= i_req.rd;
            if (i_req.rd)
            begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    assign o_rdata       = rdata_ff;
    assign o_rvalid      = rvalid_ff;
    assign o_fraction    = frac_ff;
    assign o_alarm_match = alarm_match_ff;
    assign o_alarm_pulse = alarm_pulse_ff;

endmodule : rtcb_regs

/* verif/rtcb_regs_checker.sv */
// rtcb_regs_checker: port assertions for the decimal clock registers
`timescale 1ns/1ps
module rtcb_regs_checker
    import rtcb_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire rtcb_req_t  i_req,
    input  wire rtcb_mode_t i_mode,
    input  wire logic       i_tick_1024,
    input  wire logic [7:0] o_rdata,
    input  wire logic       o_rvalid,
    input  wire logic [9:0] o_fraction,
    input  wire logic       o_alarm_match,
    input  wire logic       o_alarm_pulse
);
    // ---------------------------------------------------------
    // helpers
    // ---------------------------------------------------------
    logic on;
    logic ss_wr;
    assign on    = i_mode.access_decimal_select & i_mode.decimal_counter_run;
    assign ss_wr = i_req.wr & on & (i_req.addr == RTCB_ADDR_SS);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    // ---------------------------------------------------------
    // properties
    // ---------------------------------------------------------
    property p_rd_answer; i_req.rd |=> o_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_quiet; !i_req.rd |=> !o_rvalid; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
    property p_refused; i_req.rd && !on |=> o_rdata == RTCB_ZERO; endproperty
    a_refused: assert property (p_refused) else $error("read outside mode");
    property p_unmapped; i_req.rd && i_req.addr > RTCB_ADDR_ALM_DAY |=> o_rdata == RTCB_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_ss_top; i_req.rd && i_req.addr == RTCB_ADDR_SS |=> !o_rdata[7]; endproperty
    a_ss_top: assert property (p_ss_top) else $error("seconds bit 7 set");
    property p_frac_clear; ss_wr |=> o_fraction == RTCB_FRAC_ZERO; endproperty
    a_frac_clear: assert property (p_frac_clear) else $error("fraction kept");
    property p_frac_step;
        i_mode.decimal_counter_run && i_tick_1024 && !ss_wr
            |=> o_fraction == $past(o_fraction) + 10'h001;
    endproperty
    a_frac_step: assert property (p_frac_step) else $error("fraction step");
    property p_frac_hold;
        !(i_mode.decimal_counter_run && i_tick_1024) && !ss_wr |=> $stable(o_fraction);
    endproperty
    a_frac_hold: assert property (p_frac_hold) else $error("fraction moved");
    property p_no_run; !i_mode.decimal_counter_run |=> !o_alarm_match; endproperty
    a_no_run: assert property (p_no_run) else $error("alarm while stopped");
    property p_pulse_edge; o_alarm_pulse |-> o_alarm_match && !$past(o_alarm_match); endproperty
    a_pulse_edge: assert property (p_pulse_edge) else $error("pulse off edge");
    property p_pulse_rise;
        $rose(o_alarm_match) && i_mode.alarm_irq_en && $past(i_mode.alarm_irq_en)
            |-> o_alarm_pulse;
    endproperty
    a_pulse_rise: assert property (p_pulse_rise) else $error("pulse missing");
    c_pulse: cover property (o_alarm_pulse);
    c_wrap: cover property (o_fraction == RTCB_FRAC_LAST && i_tick_1024);
    c_refused: cover property (i_req.rd && !on);
endmodule : rtcb_regs_checker

bind rtcb_regs rtcb_regs_checker u_chk (
    .i_clock      (i_clock),
    .i_resetn     (i_resetn),
    .i_req        (i_req),
    .i_mode       (i_mode),
    .i_tick_1024  (i_tick_1024),
    .o_rdata      (o_rdata),
    .o_rvalid     (o_rvalid),
    .o_fraction   (o_fraction),
    .o_alarm_match(o_alarm_match),
    .o_alarm_pulse(o_alarm_pulse)
);

/* verif/rtcb_host_model.sv */
// rtcb_host_model: host side of the register strobe port
`timescale 1ns/1ps
module rtcb_host_model
    import rtcb_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output rtcb_req_t       o_req
);
    // ---------------------------------------------------------
    // access tasks
    // ---------------------------------------------------------
    initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 4'hf, wdata: 8'h00};
    // callers may hand a day-of-week value that is not one-hot, such as 8'hc0
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clock);
        o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clock);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d, output logic ok);
        @(negedge i_clock);
        o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge i_clock);
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        ok = (i_rvalid === 1'b1);
        d  = i_rdata;
    endtask : rd_reg
endmodule : rtcb_host_model

/* verif/tb_top.sv */
// tb_top: self-checking bench for the decimal clock registers
`timescale 1ns/1ps
module tb_top
    import rtcb_pkg::*;
();
    logic       clock;
    logic       resetn;
    rtcb_mode_t mode;
    logic       tick;
    rtcb_req_t  req;
    logic [7:0] rdata;
    logic       rvalid;
    logic [9:0] fraction;
    logic       match;
    logic       pulse;
    int         num_errors;
    int         total_checks;
    logic [7:0] rst_exp [10] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80,
                                 8'h80, 8'h80};
    logic [7:0] msk_wr  [10] = '{8'hff, 8'hff, 8'hff, 8'hc0, 8'hff, 8'hff, 8'hff, 8'hff,
                                 8'hff, 8'hff};
    logic [7:0] msk_exp [10] = '{8'h7f, 8'h7f, 8'h3f, 8'h40, 8'h3f, 8'h1f, 8'hff, 8'hff,
                                 8'hff, 8'hff};
    logic [7:0] cal_set [7]  = '{8'h59, 8'h59, 8'h23, 8'h40, 8'h28, 8'h02, 8'h04};
    logic [7:0] cal_exp [7]  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04};
    logic [25:0] alm    [9]  = '{{24'h808080, 2'b00}, {24'h008080, 2'b01}, {24'h018080, 2'b00},
                                 {24'h800080, 2'b01}, {24'h800180, 2'b00}, {24'h808003, 2'b01},
                                 {24'h80807e, 2'b00}, {24'h808029, 2'b11}, {24'h808028, 2'b10}};

    always #50 clock = ~clock;

    rtcb_host_model u_host (.i_clock(clock), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));
    rtcb_regs u_dut (
        .i_clock      (clock),
        .i_resetn     (resetn),
        .i_req        (req),
        .i_mode       (mode),
        .i_tick_1024  (tick),
        .o_rdata      (rdata),
        .o_rvalid     (rvalid),
        .o_fraction   (fraction),
        .o_alarm_match(match),
        .o_alarm_pulse(pulse)
    );
    // ---------------------------------------------------------
    // tasks
    // ---------------------------------------------------------
    task automatic stop_test();
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk_frac(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_frac
    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_flag
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        u_host.rd_reg(a, d, ok);
        if (ok !== 1'b1)
        begin
            num_errors++;
            stop_test();
        end
        else
            chk8(d, exp);
    endtask : rd_chk
    task automatic ticks(input int n);
        repeat (n)
        begin
            @(negedge clock);
            tick = 1'b1;
            @(negedge clock);
            tick = 1'b0;
        end
    endtask : ticks
    task automatic set_mode(input logic a, input logic r, input logic s, input logic q);
        @(negedge clock);
        mode = '{a, r, s, q};
    endtask : set_mode
    // ---------------------------------------------------------
    // sequence
    // ---------------------------------------------------------
    initial
    begin
        #5000000;
        num_errors++;
        stop_test();
    end
    initial
    begin
        int i;
        clock = 1'b0;
        resetn = 1'b0;
        tick = 1'b0;
        mode = '{1'b1, 1'b1, 1'b0, 1'b0};
        num_errors = 0;
        total_checks = 0;
        repeat (6) @(negedge clock);
        resetn = 1'b1;
        for (i = 0; i < 10; i++)
            rd_chk(4'(i), rst_exp[i]);
        for (i = 0; i < 10; i++)
        begin
            u_host.wr_reg(4'(i), msk_wr[i]);
            rd_chk(4'(i), msk_exp[i]);
        end
        u_host.wr_reg(4'ha, 8'hff);
        rd_chk(4'ha, 8'h00);
        for (i = 0; i < 2; i++)
        begin
            set_mode(i == 0, i == 1, 1'b0, 1'b0);
            u_host.wr_reg(RTCB_ADDR_SS, 8'h00);
            rd_chk(RTCB_ADDR_SS, 8'h00);
            set_mode(1'b1, 1'b1, 1'b0, 1'b0);
            rd_chk(RTCB_ADDR_SS, 8'h7f);
        end
        ticks(5);
        chk_frac(fraction, 10'h005);
        u_host.wr_reg(RTCB_ADDR_SS, 8'h30);
        chk_frac(fraction, RTCB_FRAC_ZERO);
        rd_chk(RTCB_ADDR_SS, 8'h30);
        for (i = 6; i >= 0; i--)
            u_host.wr_reg(4'(i), cal_set[i]);
        ticks(1024);
        for (i = 0; i < 7; i++)
            rd_chk(4'(i), cal_exp[i]);
        for (i = 0; i < 9; i++)
        begin
            u_host.wr_reg(RTCB_ADDR_ALM_MM, alm[i][25:18]);
            u_host.wr_reg(RTCB_ADDR_ALM_HH, alm[i][17:10]);
            u_host.wr_reg(RTCB_ADDR_ALM_DAY, alm[i][9:2]);
            set_mode(1'b1, 1'b1, alm[i][1], 1'b1);
            repeat (3) @(negedge clock);
            chk_flag(match, alm[i][0]);
        end
        u_host.wr_reg(RTCB_ADDR_ALM_DAY, 8'h29);
        @(negedge clock);
        chk_flag(pulse, 1'b1);
        @(negedge clock);
        chk_flag(pulse, 1'b0);
        set_mode(1'b1, 1'b1, 1'b1, 1'b0);
        u_host.wr_reg(RTCB_ADDR_ALM_DAY, 8'h28);
        u_host.wr_reg(RTCB_ADDR_ALM_DAY, 8'h29);
        @(negedge clock);
        chk_flag(pulse, 1'b0);
        chk_flag(match, 1'b1);
        u_host.wr_reg(RTCB_ADDR_ALM_MM, 8'h00);
        set_mode(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (3) @(negedge clock);
        chk_flag(match, 1'b0);
        stop_test();
    end
endmodule : tb_top
